//--- logic/acc_consts.svh
// Constants for the channel correction control block: reset values, codes and widths.
// Assumes inclusion by bare name from the package and modules of this block.
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH
`define ACC_COEF_W        24
`define ACC_GAIN_DEFAULT  24'hc00000
`define ACC_GAIN_UNITY    24'h800000
`define ACC_OFFS_DEFAULT  24'h000000
`define ACC_OFFS_ZERO     24'h000000
`define ACC_SEL_NONE      4'h0
`define ACC_NUM_CHAN      16
`define ACC_MODE_PD_RESET 2'h1
`define ACC_PSTATE_RESET  2'h2
`define ACC_PSTATE_ON     2'h0
`define ACC_CNFG_W        24
`define ACC_CNFG_DEFAULT  24'h100000
`define ACC_CNFG_KEEP     24'he00000
`define ACC_CCTRL_W       24
`define ACC_CCTRL_DEFAULT 24'h000000
`define ACC_CCTRL_SEL_LSB 8
`define ACC_CNFG_HGR_LSB  6
`define ACC_RST_CYCLES    4
`endif

//--- logic/acc_pkg.sv
// Types shared by the channel correction control block.
// Assumes acc_consts.svh is on the include path.
`include "acc_consts.svh"
package acc_pkg;
	typedef enum logic [1:0] {
		ACC_MODE_SINGLE      = 2'h0,
		ACC_MODE_PD          = 2'h1,
		ACC_MODE_CONT_SINGLE = 2'h2,
		ACC_MODE_CONT        = 2'h3
	} acc_mode_e;
	typedef enum logic [1:0] {
		ACC_ST_IDLE  = 2'h0,
		ACC_ST_CONV  = 2'h1,
		ACC_ST_RESET = 2'h2
	} acc_state_e;
	typedef struct packed {
		logic [3:0]  chan;
		logic        is_gain;
		logic        wr;
		logic [23:0] data;
	} acc_corr_req_s;
	typedef struct packed {
		logic        valid;
		logic signed [2:0] dig_gain;
		logic [1:0]  range;
	} acc_chan_info_s;
	typedef struct packed {
		logic [23:0] gain;
		logic [23:0] offset;
	} acc_coef_s;
endpackage

//--- logic/acc_chan_decode.sv
// Decodes the conversion input select into validity, digital gain and range.
// Assumes a registered select and range field from the caller.
`timescale 1ns/10ps
module acc_chan_decode
	import acc_pkg::*;
(
	// Selection
	input  wire logic [3:0]     sel_in,
	input  wire logic [1:0]     hi_gain_pair_range_in,
	// Result
	output acc_chan_info_s      info_out
);
	always_comb begin
		info_out = '0;
		info_out.range = 2'h0;
		case (sel_in)
			4'h1, 4'h3, 4'h4, 4'hd: begin
				info_out.valid = 1'b1;
				info_out.dig_gain = 3'sh2;
			end
			4'h2, 4'h5, 4'he: begin
				info_out.valid = 1'b1;
				info_out.dig_gain = -3'sh2;
			end
			4'h6, 4'h9, 4'hf: begin
				info_out.valid = 1'b1;
				info_out.dig_gain = 3'sh1;
			end
			4'hc: begin
				info_out.valid = 1'b1;
				info_out.dig_gain = 3'sh2;
				info_out.range = hi_gain_pair_range_in;
			end
			default: begin
				info_out = '0;
			end
		endcase
	end
endmodule

//--- logic/acc_coef_store.sv
// Per-channel offset and gain store with a write port and two read ports.
// Assumes the caller qualifies writes and supplies clear for resets.
`timescale 1ns/10ps
`include "acc_consts.svh"
module acc_coef_store
	import acc_pkg::*;
#(
	parameter int NUM_CHAN = `ACC_NUM_CHAN
)(
	// Clock and reset
	input  wire logic           sys_clk_in,
	input  wire logic           rst_n_in,
	input  wire logic           clear_in,
	// Write port
	input  wire logic           wr_in,
	input  wire logic           is_gain_in,
	input  wire logic [3:0]     wr_chan_in,
	input  wire logic [23:0]    wr_data_in,
	// Read ports
	input  wire logic [3:0]     host_chan_in,
	input  wire logic [3:0]     conv_chan_in,
	output acc_coef_s           host_coef_out,
	output acc_coef_s           conv_coef_out
);
	acc_coef_s mem [NUM_CHAN];
	initial begin
		if (NUM_CHAN != 16)
			$error("NUM_CHAN must be 16 to match the 4-bit select");
	end
	// Every channel keeps its own set; the converter reads its channel's set.
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < NUM_CHAN; i++) begin
				mem[i] <= {`ACC_GAIN_DEFAULT, `ACC_OFFS_DEFAULT};
			end
		end else if (clear_in) begin
			for (int i = 0; i < NUM_CHAN; i++) begin
				mem[i] <= {`ACC_GAIN_DEFAULT, `ACC_OFFS_DEFAULT};
			end
		end else if (wr_in) begin
			if (is_gain_in)
				mem[wr_chan_in].gain <= wr_data_in;
			else
				mem[wr_chan_in].offset <= wr_data_in;
		end
	end
	assign host_coef_out = mem[host_chan_in];
	assign conv_coef_out = mem[conv_chan_in];
endmodule

//--- logic/acc_ctrl.sv
// Top of the channel correction control block: configuration, conversion
// sequencing, correction interlocks, software reset and thermal flags.
// Assumes a host decoder outside that turns serial frames into the strobes below.
`timescale 1ns/10ps
`include "acc_consts.svh"

// Overview of operation
// - Decode 4-bit select into input and gain.
// - Correction access allowed while running or stopped.
// - Correction write to active channel aborts conversion.
// - In continuous modes that write stops conversions.
// - Two global bypass bits for gain, offset.
// - Gain bypass uses unity coefficient 800000h.
// - Gain coefficient defaults to C00000h.
// - Offset bypass uses zero offset.
// - Software reset clears converter registers and state.
// - Hardware reset restores everything, stops conversion.
// - Thermal warning sets at 145, clears below 135.
// - Thermal warning interrupt is maskable.
// - Thermal shutdown flag drives interrupt unconditionally.
// - Shutdown resets config, keeps reference and check bits.
// - Channel pointer selects correction data registers.
// - Per-channel coefficients applied to converted channel.
module acc_ctrl
	import acc_pkg::*;
#(
	parameter int RST_CYCLES = `ACC_RST_CYCLES
)(
	// Clock and reset
	input  wire logic           sys_clk_in,
	input  wire logic           rst_n_in,
	// Configuration writes
	input  wire logic           general_configuration_wr_in,
	input  wire logic [23:0]    general_configuration_in,
	input  wire logic           general_channel_control_wr_in,
	input  wire logic [23:0]    general_channel_control_in,
	input  wire logic           converter_control_one_wr_in,
	input  wire logic           converter_power_down_in,
	input  wire logic           converter_control_two_wr_in,
	input  wire logic           gain_correction_bypass_in,
	input  wire logic           offset_correction_bypass_in,
	input  wire logic           converter_command_wr_in,
	input  wire logic [1:0]     converter_operating_mode_in,
	input  wire logic           thermal_warning_mask_in,
	// Correction access
	input  wire logic           correction_channel_pointer_wr_in,
	input  wire logic [3:0]     correction_channel_pointer_in,
	input  wire logic           correction_wr_in,
	input  wire logic           correction_is_gain_in,
	input  wire logic [23:0]    correction_data_in,
	// Converter and temperature events
	input  wire logic           conversion_done_in,
	input  wire logic           temp_warn_rise_in,
	input  wire logic           temp_warn_fall_in,
	input  wire logic           temp_shutdown_in,
	// Configuration readback
	output logic [23:0]         general_configuration_out,
	output logic [23:0]         general_channel_control_out,
	output logic [3:0]          conversion_input_select_out,
	output logic [1:0]          hi_gain_pair_range_out,
	output logic                converter_power_down_out,
	output logic                gain_correction_bypass_out,
	output logic                offset_correction_bypass_out,
	output logic [1:0]          converter_operating_mode_out,
	output logic [3:0]          correction_channel_pointer_out,
	// Correction readback and applied coefficients
	output logic [23:0]         correction_gain_out,
	output logic [23:0]         correction_offset_out,
	output logic [23:0]         applied_gain_out,
	output logic [23:0]         applied_offset_out,
	output logic signed [2:0]   digital_gain_out,
	output logic                input_valid_out,
	// Converter control and status
	output logic                converting_out,
	output logic                conversion_abort_out,
	output logic [1:0]          power_state_status_out,
	output logic                analog_output_hiz_out,
	output logic                filter_clear_out,
	// Thermal status and interrupt
	output logic                thermal_warning_flag_out,
	output logic                thermal_shutdown_flag_out,
	output logic                int_n_out
);
	initial begin
		if (RST_CYCLES < 1 || RST_CYCLES > 255)
			$error("RST_CYCLES must lie in 1..255");
	end

	acc_state_e     state;
	acc_mode_e      mode;
	acc_chan_info_s info;
	acc_coef_s      host_coef;
	acc_coef_s      conv_coef;
	logic [7:0]     rst_cnt;
	logic [3:0]     sel;
	logic           pd;
	logic           warn_mask;
	logic           hit_active;
	logic           sw_reset_start;
	logic           sw_clear;
	logic           is_cont;

	function automatic logic cont_mode(input acc_mode_e m);
		cont_mode = (m == ACC_MODE_CONT) || (m == ACC_MODE_CONT_SINGLE);
	endfunction

	assign sel = general_channel_control_out[`ACC_CCTRL_SEL_LSB +: 4];
	assign is_cont = cont_mode(mode);
	// Only a write to the channel in conversion interferes.
	assign hit_active = correction_wr_in && (state == ACC_ST_CONV) &&
		(correction_channel_pointer_out == sel);
	// A reset starts on the mode write once power-down is set, or set in the same cycle.
	assign sw_reset_start = converter_command_wr_in &&
		(converter_operating_mode_in == `ACC_MODE_PD_RESET) &&
		(pd || (converter_control_one_wr_in && converter_power_down_in));
	assign sw_clear = (state == ACC_ST_RESET) && (rst_cnt == 8'h1);

	acc_chan_decode u_decode (
		.sel_in                (sel),
		.hi_gain_pair_range_in (general_configuration_out[`ACC_CNFG_HGR_LSB +: 2]),
		.info_out              (info)
	);

	acc_coef_store u_store (
		.sys_clk_in    (sys_clk_in),
		.rst_n_in      (rst_n_in),
		.clear_in      (sw_clear),
		.wr_in         (correction_wr_in),
		.is_gain_in    (correction_is_gain_in),
		.wr_chan_in    (correction_channel_pointer_out),
		.wr_data_in    (correction_data_in),
		.host_chan_in  (correction_channel_pointer_out),
		.conv_chan_in  (sel),
		.host_coef_out (host_coef),
		.conv_coef_out (conv_coef)
	);

	// General configuration and channel control; shutdown keeps only the kept bits.
	// Shutdown outranks a host write in the same cycle, so the defaults always land.
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			general_configuration_out <= `ACC_CNFG_DEFAULT;
			general_channel_control_out <= `ACC_CCTRL_DEFAULT;
		end else if (temp_shutdown_in) begin
			general_configuration_out <= (general_configuration_out & `ACC_CNFG_KEEP) |
				(`ACC_CNFG_DEFAULT & ~`ACC_CNFG_KEEP);
			general_channel_control_out <= `ACC_CCTRL_DEFAULT;
		end else begin
			if (general_configuration_wr_in)
				general_configuration_out <= general_configuration_in;
			if (general_channel_control_wr_in)
				general_channel_control_out <= general_channel_control_in;
		end
	end

	// Converter registers, cleared by the software reset.
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pd <= 1'b0;
			gain_correction_bypass_out <= 1'b0;
			offset_correction_bypass_out <= 1'b0;
			mode <= ACC_MODE_SINGLE;
			correction_channel_pointer_out <= 4'h0;
		end else if (sw_clear) begin
			pd <= 1'b0;
			gain_correction_bypass_out <= 1'b0;
			offset_correction_bypass_out <= 1'b0;
			mode <= ACC_MODE_SINGLE;
			correction_channel_pointer_out <= 4'h0;
		end else begin
			if (converter_control_one_wr_in)
				pd <= converter_power_down_in;
			if (converter_control_two_wr_in) begin
				gain_correction_bypass_out <= gain_correction_bypass_in;
				offset_correction_bypass_out <= offset_correction_bypass_in;
			end
			if (converter_command_wr_in)
				mode <= acc_mode_e'(converter_operating_mode_in);
			if (correction_channel_pointer_wr_in)
				correction_channel_pointer_out <= correction_channel_pointer_in;
		end
	end

	// Conversion sequencer. An aborting correction write drops to idle in every mode;
	// in the continuous modes nothing restarts until the host issues a new command,
	// so the halt after an abort needs no state of its own.
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= ACC_ST_IDLE;
			rst_cnt <= 8'h0;
		end else begin
			case (state)
				ACC_ST_IDLE: begin
					if (sw_reset_start) begin
						state <= ACC_ST_RESET;
						rst_cnt <= 8'(RST_CYCLES);
					end else if (converter_command_wr_in && !pd && info.valid &&
						converter_operating_mode_in != `ACC_MODE_PD_RESET)
						state <= ACC_ST_CONV;
				end
				ACC_ST_CONV: begin
					if (sw_reset_start) begin
						state <= ACC_ST_RESET;
						rst_cnt <= 8'(RST_CYCLES);
					end else if (hit_active && is_cont)
						state <= ACC_ST_IDLE;
					else if (hit_active)
						state <= ACC_ST_IDLE;
					else if (conversion_done_in && !is_cont)
						state <= ACC_ST_IDLE;
				end
				ACC_ST_RESET: begin
					if (rst_cnt == 8'h1)
						state <= ACC_ST_IDLE;
					rst_cnt <= rst_cnt - 8'h1;
				end
				default: begin
					state <= ACC_ST_IDLE;
				end
			endcase
		end
	end

	// Converter status outputs. Power state reads powered down while the power-down
	// bit is set or a software reset runs, so a polling host sees it at once.
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			converting_out <= 1'b0;
			conversion_abort_out <= 1'b0;
			power_state_status_out <= `ACC_PSTATE_RESET;
			analog_output_hiz_out <= 1'b1;
			filter_clear_out <= 1'b1;
			converter_power_down_out <= 1'b0;
			converter_operating_mode_out <= 2'h0;
		end else begin
			converting_out <= (state == ACC_ST_CONV) && !hit_active;
			conversion_abort_out <= hit_active;
			power_state_status_out <= (state == ACC_ST_RESET || sw_clear || pd) ?
				`ACC_PSTATE_RESET : `ACC_PSTATE_ON;
			analog_output_hiz_out <= 1'b0;
			filter_clear_out <= sw_reset_start || hit_active;
			converter_power_down_out <= pd;
			converter_operating_mode_out <= mode;
		end
	end

	// Applied coefficients with global bypass.
	// The bypass bits act on every channel at once and leave the stored sets intact.
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			applied_gain_out <= `ACC_GAIN_DEFAULT;
			applied_offset_out <= `ACC_OFFS_DEFAULT;
			correction_gain_out <= `ACC_GAIN_DEFAULT;
			correction_offset_out <= `ACC_OFFS_DEFAULT;
			digital_gain_out <= 3'sh0;
			input_valid_out <= 1'b0;
			conversion_input_select_out <= `ACC_SEL_NONE;
			hi_gain_pair_range_out <= 2'h0;
		end else begin
			applied_gain_out <= gain_correction_bypass_out ?
				`ACC_GAIN_UNITY : conv_coef.gain;
			applied_offset_out <= offset_correction_bypass_out ?
				`ACC_OFFS_ZERO : conv_coef.offset;
			correction_gain_out <= host_coef.gain;
			correction_offset_out <= host_coef.offset;
			digital_gain_out <= info.dig_gain;
			input_valid_out <= info.valid;
			conversion_input_select_out <= sel;
			hi_gain_pair_range_out <= info.range;
		end
	end

	// Thermal flags and interrupt.
	// A rise and a fall in the same cycle leave the warning set.
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			thermal_warning_flag_out <= 1'b0;
			thermal_shutdown_flag_out <= 1'b0;
			warn_mask <= 1'b1;
		end else begin
			warn_mask <= thermal_warning_mask_in;
			if (temp_warn_rise_in)
				thermal_warning_flag_out <= 1'b1;
			else if (temp_warn_fall_in)
				thermal_warning_flag_out <= 1'b0;
			thermal_shutdown_flag_out <= temp_shutdown_in;
		end
	end

	// The shutdown flag ignores the mask, so it always pulls the interrupt low.
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			int_n_out <= 1'b1;
		else
			int_n_out <= !((thermal_warning_flag_out && !warn_mask) ||
				thermal_shutdown_flag_out);
	end
endmodule

//--- sim/acc_ctrl_assertions.sv
// Port checker for the channel correction control block.
// Assumes binding into acc_ctrl, one clock and an asynchronous low reset.
`timescale 1ns/10ps
`include "acc_consts.svh"
module acc_ctrl_assertions (
	input wire logic        sys_clk_in,
	input wire logic        rst_n_in,
	input wire logic        converter_command_wr_in,
	input wire logic        general_configuration_wr_in,
	input wire logic        general_channel_control_wr_in,
	input wire logic        thermal_warning_mask_in,
	input wire logic        temp_warn_rise_in,
	input wire logic        temp_warn_fall_in,
	input wire logic [23:0] general_configuration_out,
	input wire logic [23:0] general_channel_control_out,
	input wire logic        gain_correction_bypass_out,
	input wire logic        offset_correction_bypass_out,
	input wire logic [1:0]  converter_operating_mode_out,
	input wire logic [23:0] applied_gain_out,
	input wire logic [23:0] applied_offset_out,
	input wire logic        converting_out,
	input wire logic        conversion_abort_out,
	input wire logic        analog_output_hiz_out,
	input wire logic        thermal_warning_flag_out,
	input wire logic        thermal_shutdown_flag_out,
	input wire logic        int_n_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	sequence s_cont_abort;
		conversion_abort_out && converter_operating_mode_out[1];
	endsequence
	sequence s_no_cmd;
		!converter_command_wr_in [*3];
	endsequence
	a_abort_stops: assert property (conversion_abort_out |-> !converting_out)
		else $error("abort while converting");
	a_cont_halts: assert property (s_cont_abort ##1 s_no_cmd |-> !converting_out)
		else $error("conversions resumed after abort");
	a_gain_unity: assert property (gain_correction_bypass_out [*3]
		|-> applied_gain_out == `ACC_GAIN_UNITY) else $error("gain bypass not unity");
	a_offs_zero: assert property (offset_correction_bypass_out [*3]
		|-> applied_offset_out == `ACC_OFFS_ZERO) else $error("offset bypass not zero");
	a_warn_sets: assert property (temp_warn_rise_in |=> thermal_warning_flag_out)
		else $error("warning not set");
	a_warn_holds: assert property (thermal_warning_flag_out && !temp_warn_fall_in
		|=> thermal_warning_flag_out) else $error("warning cleared early");
	a_warn_masked: assert property ((thermal_warning_mask_in &&
		!thermal_shutdown_flag_out) [*3] |-> int_n_out) else $error("masked warning interrupts");
	a_shdn_int: assert property (thermal_shutdown_flag_out [*2] |-> !int_n_out)
		else $error("shutdown without interrupt");
	a_int_idle: assert property ((!thermal_warning_flag_out &&
		!thermal_shutdown_flag_out) [*2] |-> int_n_out) else $error("interrupt without source");
	a_shdn_dflt: assert property ((thermal_shutdown_flag_out [*3] ##0
		!$past(general_configuration_wr_in) && !$past(general_channel_control_wr_in)) |->
		(general_configuration_out & ~`ACC_CNFG_KEEP) == (`ACC_CNFG_DEFAULT & ~`ACC_CNFG_KEEP)
		&& general_channel_control_out == `ACC_CCTRL_DEFAULT) else $error("shutdown defaults");
	a_rst_release: assert property ($rose(rst_n_in)
		|-> analog_output_hiz_out && !converting_out) else $error("reset state");
endmodule
bind acc_ctrl acc_ctrl_assertions acc_ctrl_assertions_inst (.*);

//--- sim/acc_host.sv
// Host model: correction pointer and data writes, converter commands.
// Assumes the bench clock; each strobe rises at a falling edge for one cycle.
`timescale 1ns/10ps
module acc_host (
	// Clock and status
	input  wire logic       sys_clk_in,
	input  wire logic [1:0] power_state_status_in,
	// Strobes and data
	output logic            ptr_wr_out,
	output logic [3:0]      ptr_out,
	output logic            coef_wr_out,
	output logic            is_gain_out,
	output logic [23:0]     data_out,
	output logic            ctl1_wr_out,
	output logic            pd_out,
	output logic            cmd_wr_out,
	output logic [1:0]      mode_out
);
	initial begin
		{ptr_wr_out, ptr_out, coef_wr_out, is_gain_out, data_out} = '0;
		{ctl1_wr_out, pd_out, cmd_wr_out, mode_out} = '0;
	end
	task automatic set_ptr(input logic [3:0] ch);
		@(negedge sys_clk_in);
		ptr_out = ch;
		ptr_wr_out = 1'b1;
		@(negedge sys_clk_in);
		ptr_wr_out = 1'b0;
		ptr_out = ~ch;
	endtask
	// Callers pick a channel other than the converted one unless an abort is wanted.
	task automatic wr_coef(input logic g, input logic [23:0] d);
		@(negedge sys_clk_in);
		is_gain_out = g;
		data_out = d;
		coef_wr_out = 1'b1;
		@(negedge sys_clk_in);
		coef_wr_out = 1'b0;
		data_out = ~d;
	endtask
	task automatic command(input logic [1:0] m);
		@(negedge sys_clk_in);
		mode_out = m;
		cmd_wr_out = 1'b1;
		@(negedge sys_clk_in);
		cmd_wr_out = 1'b0;
	endtask
	task automatic sw_reset(output bit ok);
		@(negedge sys_clk_in);
		pd_out = 1'b1;
		ctl1_wr_out = 1'b1;
		@(negedge sys_clk_in);
		ctl1_wr_out = 1'b0;
		pd_out = 1'b0;
		command(2'h1);
		ok = 1'b0;
		for (int i = 0; i < 40 && !ok; i++) begin
			ok = power_state_status_in === 2'h2;
			@(negedge sys_clk_in);
		end
	endtask
endmodule

//--- sim/acc_ctrl_tb.sv
// Self-checking bench for the channel correction control block.
// Assumes acc_ctrl, acc_host and the checker are compiled before it.
`timescale 1ns/10ps
`include "acc_consts.svh"
module acc_ctrl_tb;
	logic        sys_clk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic        general_configuration_wr_in, general_channel_control_wr_in;
	logic        converter_control_one_wr_in, converter_power_down_in, converter_command_wr_in;
	logic        converter_control_two_wr_in, gain_correction_bypass_in;
	logic        offset_correction_bypass_in, thermal_warning_mask_in, conversion_done_in;
	logic        correction_channel_pointer_wr_in, correction_wr_in, correction_is_gain_in;
	logic        temp_warn_rise_in, temp_warn_fall_in, temp_shutdown_in;
	logic        converter_power_down_out, gain_correction_bypass_out, input_valid_out;
	logic        offset_correction_bypass_out, converting_out, conversion_abort_out;
	logic        analog_output_hiz_out, filter_clear_out, int_n_out;
	logic        thermal_warning_flag_out, thermal_shutdown_flag_out;
	logic [1:0]  converter_operating_mode_in, converter_operating_mode_out;
	logic [1:0]  hi_gain_pair_range_out, power_state_status_out;
	logic [3:0]  correction_channel_pointer_in, correction_channel_pointer_out;
	logic [3:0]  conversion_input_select_out;
	logic [23:0] general_configuration_in, general_channel_control_in, correction_data_in;
	logic [23:0] general_configuration_out, general_channel_control_out;
	logic [23:0] correction_gain_out, correction_offset_out, applied_gain_out, applied_offset_out;
	logic signed [2:0] digital_gain_out;
	int          fails = 0;
	int          n_checks = 0;
	int          gt[16] = '{0, 2, -2, 2, 2, -2, 1, 0, 0, 1, 0, 0, 2, 2, -2, 1};

	acc_ctrl #(.RST_CYCLES(2)) acc_ctrl_inst (.*);
	acc_host acc_host_inst (.sys_clk_in(sys_clk_in), .power_state_status_in(power_state_status_out),
		.ptr_wr_out(correction_channel_pointer_wr_in), .ptr_out(correction_channel_pointer_in),
		.coef_wr_out(correction_wr_in), .is_gain_out(correction_is_gain_in),
		.data_out(correction_data_in), .ctl1_wr_out(converter_control_one_wr_in),
		.pd_out(converter_power_down_in), .cmd_wr_out(converter_command_wr_in),
		.mode_out(converter_operating_mode_in));

	always #10 sys_clk_in = ~sys_clk_in;

	task automatic test_done();
		if (fails == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge sys_clk_in);
	endtask
	// Kinds: 0 config, 1 channel control, 2 bypass pair, 3 done, 4 warn rise, 5 warn fall.
	task automatic drive(input int k, input logic [23:0] d);
		@(negedge sys_clk_in);
		general_configuration_in = d;
		general_channel_control_in = d;
		gain_correction_bypass_in = d[1];
		offset_correction_bypass_in = d[0];
		general_configuration_wr_in = (k == 0);
		general_channel_control_wr_in = (k == 1);
		converter_control_two_wr_in = (k == 2);
		conversion_done_in = (k == 3);
		temp_warn_rise_in = (k == 4);
		temp_warn_fall_in = (k == 5);
		@(negedge sys_clk_in);
		{temp_warn_fall_in, temp_warn_rise_in, conversion_done_in, converter_control_two_wr_in,
			general_channel_control_wr_in, general_configuration_wr_in} = '0;
	endtask
	task automatic wait_abort(output bit seen);
		seen = 1'b0;
		for (int i = 0; i < 3; i++) begin
			seen |= conversion_abort_out === 1'b1;
			@(negedge sys_clk_in);
		end
	endtask
	task automatic t_reset();
		chk(converting_out, 24'h0, "hstop");
		chk(analog_output_hiz_out, 24'h1, "hiz");
		chk(filter_clear_out, 24'h1, "flt");
		chk(general_configuration_out, `ACC_CNFG_DEFAULT, "hcfg");
		chk(power_state_status_out, `ACC_PSTATE_RESET, "hps");
		chk(int_n_out, 24'h1, "hint");
	endtask
	task automatic t_decode();
		for (int i = 0; i < 16; i++) begin
			drive(1, 24'(i) << 8);
			idle(2);
			chk(conversion_input_select_out, 24'(i), "sel");
			chk(input_valid_out, 24'(gt[i] != 0), "valid");
			if (gt[i] != 0) chk({21'h0, digital_gain_out}, {21'h0, 3'(gt[i])}, "dg");
		end
		drive(0, `ACC_CNFG_DEFAULT | (24'h2 << `ACC_CNFG_HGR_LSB));
		drive(1, 24'h000c00);
		idle(2);
		chk(hi_gain_pair_range_out, 24'h2, "range");
	endtask
	task automatic t_coef();
		acc_host_inst.set_ptr(4'h3);
		idle(3);
		chk(correction_gain_out, `ACC_GAIN_DEFAULT, "gdef");
		chk(correction_offset_out, `ACC_OFFS_DEFAULT, "odef");
		chk(correction_channel_pointer_out, 24'h3, "ptr");
		acc_host_inst.set_ptr(4'h2);
		acc_host_inst.wr_coef(1'b1, 24'h123456);
		acc_host_inst.wr_coef(1'b0, 24'h000111);
		drive(1, 24'h000200);
		idle(3);
		chk(correction_gain_out, 24'h123456, "grd");
		chk(applied_gain_out, 24'h123456, "gapp");
		chk(applied_offset_out, 24'h000111, "oapp");
		drive(2, 24'h2);
		idle(3);
		chk(applied_gain_out, `ACC_GAIN_UNITY, "gbyp");
		chk(applied_offset_out, 24'h000111, "okeep");
		drive(2, 24'h1);
		idle(3);
		chk(applied_gain_out, 24'h123456, "gon");
		chk(applied_offset_out, `ACC_OFFS_ZERO, "obyp");
		drive(2, 24'h0);
		drive(1, 24'h000300);
		idle(3);
		chk(applied_gain_out, `ACC_GAIN_DEFAULT, "g3");
	endtask
	task automatic t_abort();
		bit seen;
		drive(1, 24'h000100);
		acc_host_inst.command(2'h0);
		idle(2);
		chk(converting_out, 24'h1, "start");
		acc_host_inst.set_ptr(4'h2);
		acc_host_inst.wr_coef(1'b1, 24'h400000);
		wait_abort(seen);
		chk(seen, 24'h0, "spur");
		chk(correction_gain_out, 24'h400000, "wrun");
		chk(converting_out, 24'h1, "run");
		drive(3, 24'h0);
		acc_host_inst.command(2'h3);
		acc_host_inst.set_ptr(4'h1);
		acc_host_inst.wr_coef(1'b0, 24'h000005);
		wait_abort(seen);
		chk(seen, 24'h1, "abort");
		chk(converting_out, 24'h0, "halt");
		drive(3, 24'h0);
		idle(4);
		chk(converting_out, 24'h0, "stay");
	endtask
	task automatic t_swrst();
		bit ok;
		drive(0, 24'h1000c0);
		drive(2, 24'h3);
		acc_host_inst.set_ptr(4'h5);
		acc_host_inst.wr_coef(1'b1, 24'h000abc);
		acc_host_inst.sw_reset(ok);
		if (!ok) begin
			fails++;
			$display("[ERR] %0t software reset poll timed out", $time);
			test_done();
		end
		idle(8);
		chk({gain_correction_bypass_out, offset_correction_bypass_out}, 24'h0, "byp");
		chk(converter_power_down_out, 24'h0, "pd");
		chk(power_state_status_out, `ACC_PSTATE_ON, "on");
		chk(general_configuration_out, 24'h1000c0, "keep");
		acc_host_inst.set_ptr(4'h5);
		idle(3);
		chk(correction_gain_out, `ACC_GAIN_DEFAULT, "coef");
	endtask
	task automatic t_therm();
		drive(4, 24'h0);
		idle(2);
		chk(thermal_warning_flag_out, 24'h1, "wset");
		chk(int_n_out, 24'h0, "wint");
		drive(5, 24'h0);
		idle(2);
		chk({thermal_warning_flag_out, int_n_out}, 24'h1, "wclr");
		thermal_warning_mask_in = 1'b1;
		drive(4, 24'h0);
		idle(2);
		chk({thermal_warning_flag_out, int_n_out}, 24'h3, "mask");
		drive(0, 24'hffffff);
		drive(1, 24'h00ff00);
		temp_shutdown_in = 1'b1;
		idle(3);
		chk({thermal_shutdown_flag_out, int_n_out}, 24'h2, "sd");
		chk(general_configuration_out, (24'hffffff & `ACC_CNFG_KEEP) |
			(`ACC_CNFG_DEFAULT & ~`ACC_CNFG_KEEP), "sdcfg");
		chk(general_channel_control_out, `ACC_CCTRL_DEFAULT, "sdcc");
		temp_shutdown_in = 1'b0;
		thermal_warning_mask_in = 1'b0;
		drive(5, 24'h0);
		idle(3);
		chk(int_n_out, 24'h1, "rel");
	endtask

	initial begin
		{general_configuration_wr_in, general_channel_control_wr_in, temp_shutdown_in} = '0;
		{converter_control_two_wr_in, gain_correction_bypass_in, thermal_warning_mask_in} = '0;
		{offset_correction_bypass_in, conversion_done_in, temp_warn_rise_in} = '0;
		{temp_warn_fall_in, general_configuration_in, general_channel_control_in} = '0;
		idle(12);
		t_reset();
		rst_n_in = 1'b1;
		idle(2);
		t_decode();
		t_coef();
		t_abort();
		t_swrst();
		t_therm();
		drive(1, 24'h000100);
		acc_host_inst.command(2'h3);
		idle(2);
		chk(converting_out, 24'h1, "run2");
		rst_n_in = 1'b0;
		idle(2);
		t_reset();
		rst_n_in = 1'b1;
		idle(3);
		test_done();
	end
endmodule
